/* verilog/wrgh_top.sv */
// Wide-range gauge handover controller
//
// Functional notes
// R1: Ion gauge off: report secondary pressure
// R2: Below turn-on, wait, then start ion gauge
// R3: Wait 0-499 s; rise aborts wait
// R4: Started ion gauge reports its own pressure
// R5: Failed start retried up to limit
// R6: Successful start clears attempt counter
// R7: All attempts fail: clear enable
// R8: Above turn-off: stop ion gauge, report secondary
// R9: Guard on: both pressures tested for turn-off
// R10: Reject turn-on above turn-off threshold
// R11: Active only when enabled and slot chosen
// R12: Slot either, never shared with other gauge
// R13: Enabled-at-power-up policy: start immediately; code only sets enable at reset release, then runs the normal handover
// R14: Disabled-at-power-up policy: clear enable
// R15: Single-pump-down: clear enable on first start
// R16: Active mode: third name character asterisk
// R17: No ion gauge connected: clear enable
// R18: User turns gauge off: clear enable
// R19: Reset: idle, gauge off, counter cleared
// R20: Strict comparisons for both thresholds
`timescale 1ns/1ps
`default_nettype none

module wrgh_top
  import wrgh_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WRGH_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Configuration writes
  input wire logic i_cfg_wr,
  input wire wrgh_cfg_s i_cfg,
  input wire logic i_enable_set,
  input wire logic i_enable_clr,
  input wire logic [1:0] i_partner_slot_select,
  input wire logic [1:0] i_other_ig_slot,
  input wire wrgh_policy_e i_power_up_policy,
  // Gauge status from pins
  input wire logic [WRGH_PW-1:0] i_secondary_pressure,
  input wire logic [WRGH_PW-1:0] i_ion_pressure,
  input wire logic i_ion_connected,
  input wire logic i_ion_running,
  input wire logic i_ion_start_fail,
  input wire logic i_user_ion_off,
  input wire logic [7:0] i_name_char3,
  // Outputs
  output logic o_ion_on,
  output logic [7:0] o_ion_emission,
  output logic [WRGH_PW-1:0] o_combined_pressure,
  output logic o_wide_range_enable,
  output logic o_wide_range_mode_active,
  output logic [1:0] o_partner_slot,
  output logic o_cfg_rejected,
  output logic [7:0] o_name_char3,
  output logic [3:0] o_attempts
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned SW = 2 * WRGH_PW + 5;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  // Connected bit resets high so a power-up policy is not cancelled at once
  localparam logic [SW-1:0] SYNC_RST = {{(SW-5){1'b0}}, 5'h10};
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= {i_secondary_pressure, i_ion_pressure, i_ion_connected, i_ion_running,
                   i_ion_start_fail, i_user_ion_off, 1'b0};
      sync2_ff <= sync1_ff;
    end
  end
  wire logic [WRGH_PW-1:0] sec_p = sync2_ff[SW-1 -: WRGH_PW];
  wire logic [WRGH_PW-1:0] ion_p = sync2_ff[WRGH_PW+4:5];
  wire logic ion_conn = sync2_ff[4];
  wire logic ion_run = sync2_ff[3];
  wire logic ion_fail = sync2_ff[2];
  wire logic user_off = sync2_ff[1];

  // ****************************************
  // Configuration
  // ****************************************
  wrgh_cfg_s cfg_ff;
  logic [1:0] slot_ff;
  logic enable_ff;
  logic boot_ff;
  logic rej_ff;
  wire logic cfg_ok = i_cfg.turn_on_threshold <= i_cfg.turn_off_threshold; // see R10
  wire logic wait_ok = i_cfg.turn_on_wait <= 13'(WRGH_WAIT_MAX_TENTHS); // see R3
  // Shared module refused; a match when slot none is fine
  wire logic slot_ok = (i_partner_slot_select == WRGH_SLOT_NONE)
                    || (i_partner_slot_select != i_other_ig_slot); // see R12
  wire logic slot_legal = (i_partner_slot_select == WRGH_SLOT_ONE)
                       || (i_partner_slot_select == WRGH_SLOT_TWO)
                       || (i_partner_slot_select == WRGH_SLOT_NONE);
  wire logic active = enable_ff && (slot_ff != WRGH_SLOT_NONE); // see R11

  // ****************************************
  // Handover state machine
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_TEST, ST_WAIT, ST_START, ST_RUN
  } wrgh_state_e;
  wrgh_state_e state_ff;
  wrgh_state_e nxt_state;
  logic [31:0] tick_ff;
  logic [12:0] wait_ff;
  logic [3:0] att_ff;
  logic [3:0] nxt_att;
  logic nxt_clear_en;
  logic started;

  wire logic tick = tick_ff == 32'(TICK_CYCLES - 1);
  wire logic below_on = sec_p < cfg_ff.turn_on_threshold; // see R20
  wire logic over_off = (ion_p > cfg_ff.turn_off_threshold)
                     || (cfg_ff.secondary_overpressure_guard
                         && sec_p > cfg_ff.turn_off_threshold); // see R9 R20

  always_comb begin
    nxt_state = state_ff;
    nxt_att = att_ff;
    nxt_clear_en = 1'b0;
    started = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (active) begin
          nxt_state = ST_TEST;
        end
      end
      ST_TEST: begin
        if (below_on) begin
          nxt_state = ST_WAIT; // see R2
        end
      end
      ST_WAIT: begin
        if (!below_on) begin
          nxt_state = ST_TEST; // see R3
        end else if (wait_ff >= cfg_ff.turn_on_wait) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        if (ion_run) begin
          nxt_state = ST_RUN;
          nxt_att = 4'h0; // see R6
          started = 1'b1;
        end else if (ion_fail) begin
          nxt_att = att_ff + 4'h1;
          if (att_ff + 4'h1 >= cfg_ff.start_retry_limit) begin
            nxt_clear_en = 1'b1; // see R7
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_WAIT; // see R5
          end
        end
      end
      ST_RUN: begin
        if (over_off) begin
          nxt_state = ST_TEST; // see R8
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (!active && state_ff != ST_RUN) begin
      nxt_state = ST_IDLE;
    end
    if (started && i_power_up_policy == WRGH_POL_SINGLE_PUMP_DOWN) begin
      nxt_clear_en = 1'b1; // see R15
    end
    if (!ion_conn || user_off) begin
      nxt_clear_en = 1'b1; // see R17 R18
    end
  end

  // Leave a running gauge on if the mode is dropped; the user owns it then
  wire logic ion_cmd = (state_ff == ST_START) || (state_ff == ST_RUN && !over_off);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE; // see R19
      att_ff <= 4'h0;
      tick_ff <= '0;
      wait_ff <= WRGH_WAIT_RST;
      cfg_ff <= '{turn_on_threshold: '0, turn_off_threshold: '1,
                  turn_on_wait: WRGH_WAIT_RST, start_retry_limit: WRGH_RETRY_RST,
                  start_emission_setting: 8'h00, secondary_overpressure_guard: 1'b0};
      slot_ff <= WRGH_SLOT_NONE;
      enable_ff <= 1'b0;
      boot_ff <= 1'b1;
      rej_ff <= 1'b0;
      o_ion_on <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      att_ff <= nxt_att;
      tick_ff <= (state_ff != ST_WAIT || tick) ? '0 : tick_ff + 32'h1;
      if (state_ff != ST_WAIT) begin
        wait_ff <= WRGH_WAIT_RST;
      end else if (tick) begin
        wait_ff <= wait_ff + 13'h1;
      end
      if (i_cfg_wr) begin
        rej_ff <= !(cfg_ok && wait_ok && slot_ok && slot_legal);
        if (cfg_ok && wait_ok && slot_ok && slot_legal) begin
          cfg_ff <= i_cfg;
          slot_ff <= i_partner_slot_select;
        end
      end
      boot_ff <= 1'b0;
      // Policy straps are sampled one cycle after reset release
      if (boot_ff) begin
        enable_ff <= (i_power_up_policy == WRGH_POL_ENABLED_AT_POWER_UP); // see R13 R14
      end else if (nxt_clear_en) begin
        enable_ff <= 1'b0;
      end else if (i_enable_set) begin
        enable_ff <= 1'b1;
      end else if (i_enable_clr) begin
        enable_ff <= 1'b0;
      end
      o_ion_on <= ion_cmd;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_combined_pressure <= '0;
      o_name_char3 <= 8'h00;
      o_ion_emission <= 8'h00;
    end else begin
      o_combined_pressure <= (state_ff == ST_RUN) ? ion_p : sec_p; // see R1 R4
      o_name_char3 <= active ? WRGH_ASTERISK : i_name_char3; // see R16
      o_ion_emission <= cfg_ff.start_emission_setting; // see R2
    end
  end

  assign o_wide_range_enable = enable_ff;
  assign o_wide_range_mode_active = active;
  assign o_partner_slot = slot_ff;
  assign o_cfg_rejected = rej_ff;
  assign o_attempts = att_ff;

endmodule // wrgh_top

`default_nettype wire

/* verilog/wrgh_pkg.sv */
// Package for the wide-range gauge handover controller
package wrgh_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int unsigned WRGH_PW = 16;
  localparam int unsigned WRGH_CLK_HZ = 50000000;
  // Wait is programmed in tenths of a second, 0.0 to 499.0 s
  localparam int unsigned WRGH_WAIT_UNIT_MS = 100;
  localparam int unsigned WRGH_WAIT_MAX_TENTHS = 4990;
  localparam int unsigned WRGH_TICK_CYCLES = WRGH_CLK_HZ / 1000 * WRGH_WAIT_UNIT_MS;
  localparam logic [12:0] WRGH_WAIT_RST = 13'h0000;
  localparam logic [3:0] WRGH_RETRY_RST = 4'h3;
  localparam logic [1:0] WRGH_SLOT_NONE = 2'h0;
  localparam logic [1:0] WRGH_SLOT_ONE = 2'h1;
  localparam logic [1:0] WRGH_SLOT_TWO = 2'h2;
  localparam logic [7:0] WRGH_ASTERISK = 8'h2a;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    WRGH_POL_DISABLED_AT_POWER_UP,
    WRGH_POL_ENABLED_AT_POWER_UP,
    WRGH_POL_SINGLE_PUMP_DOWN
  } wrgh_policy_e;

  typedef struct packed {
    logic [WRGH_PW-1:0] turn_on_threshold;
    logic [WRGH_PW-1:0] turn_off_threshold;
    logic [12:0] turn_on_wait;
    logic [3:0] start_retry_limit;
    logic [7:0] start_emission_setting;
    logic secondary_overpressure_guard;
  } wrgh_cfg_s;

endpackage

/* tb/wrgh_asserts.sv */
// Port checker for the gauge handover controller
`timescale 1ns/1ps
`default_nettype none
module wrgh_asserts
  import wrgh_pkg::*;
(
  // Inputs
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cfg_wr,
  input wire wrgh_cfg_s i_cfg,
  input wire logic [1:0] i_partner_slot_select,
  input wire logic [1:0] i_other_ig_slot,
  input wire logic [WRGH_PW-1:0] i_secondary_pressure,
  input wire logic i_ion_connected,
  input wire logic i_user_ion_off,
  // Outputs watched
  input wire logic o_ion_on,
  input wire logic [WRGH_PW-1:0] o_combined_pressure,
  input wire logic o_wide_range_enable,
  input wire logic o_wide_range_mode_active,
  input wire logic [1:0] o_partner_slot,
  input wire logic o_cfg_rejected,
  input wire logic [7:0] o_name_char3
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_mode_flag_def: assert property (o_wide_range_mode_active ==
    (o_wide_range_enable && o_partner_slot != 2'h0)) else $error("mode flag wrong");
  a_name_star_shown: assert property (o_wide_range_mode_active [*2] |->
    o_name_char3 == WRGH_ASTERISK) else $error("name char not starred");
  a_reject_on_above: assert property (i_cfg_wr &&
    i_cfg.turn_on_threshold > i_cfg.turn_off_threshold |=> o_cfg_rejected)
    else $error("inverted thresholds taken");
  a_reject_shared_slot: assert property (i_cfg_wr && i_other_ig_slot != 2'h0 &&
    i_partner_slot_select == i_other_ig_slot |=> o_cfg_rejected && $stable(o_partner_slot))
    else $error("shared slot taken");
  a_accept_slot_load: assert property (i_cfg_wr && i_partner_slot_select != 2'h3 &&
    i_cfg.turn_on_threshold <= i_cfg.turn_off_threshold && i_cfg.turn_on_wait <= 13'h137e
    && (i_partner_slot_select != i_other_ig_slot || i_other_ig_slot == 2'h0)
    |=> !o_cfg_rejected && o_partner_slot == $past(i_partner_slot_select))
    else $error("good write refused");
  a_disconnect_clears: assert property (!i_ion_connected [*4] |->
    !o_wide_range_enable) else $error("enable kept without gauge");
  a_user_off_clears: assert property (i_user_ion_off [*4] |->
    !o_wide_range_enable) else $error("enable kept after user off");
  a_secondary_shown: assert property ((!o_ion_on && $stable(i_secondary_pressure)) [*5]
    |-> o_combined_pressure == i_secondary_pressure) else $error("secondary not shown");
  c_ion_started: cover property ($rose(o_ion_on));
  c_write_refused: cover property (o_cfg_rejected);
  c_mode_active: cover property (o_wide_range_mode_active);
endmodule // wrgh_asserts
`default_nettype wire

/* tb/wrgh_gauge_model.sv */
// Behavioural ion gauge and secondary gauge pair
`timescale 1ns/1ps
`default_nettype none
module wrgh_gauge_model
  import wrgh_pkg::*;
(
  // Clock, reset and start command
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ion_on,
  // Chamber pressure and commanded start outcome
  input wire logic [WRGH_PW-1:0] i_chamber,
  input wire logic i_fail_mode,
  // Gauge readings
  output logic [WRGH_PW-1:0] o_secondary_pressure,
  output logic [WRGH_PW-1:0] o_ion_pressure,
  output logic o_ion_running,
  output logic o_ion_start_fail
);
  logic [2:0] strike_ff;
  logic [WRGH_PW-1:0] last_ff;
  assign o_secondary_pressure = i_chamber;
  // Off gauge must not keep its last reading alive
  assign o_ion_pressure = o_ion_running ? i_chamber + 16'h0003 : ~last_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strike_ff <= 3'h0;
      last_ff <= 16'h0000;
      o_ion_running <= 1'b0;
      o_ion_start_fail <= 1'b0;
    end else if (!i_ion_on) begin
      strike_ff <= 3'h0;
      o_ion_running <= 1'b0;
      o_ion_start_fail <= 1'b0;
    end else begin
      strike_ff <= (strike_ff == 3'h4) ? strike_ff : strike_ff + 3'h1;
      o_ion_running <= (strike_ff == 3'h4) && !i_fail_mode;
      o_ion_start_fail <= (strike_ff == 3'h4) && i_fail_mode;
      last_ff <= o_ion_pressure;
    end
  end
endmodule // wrgh_gauge_model
`default_nettype wire

/* tb/wrgh_top_test.sv */
// Self-checking bench for the gauge handover controller
`timescale 1ns/1ps
`default_nettype none
module wrgh_top_test
  import wrgh_pkg::*;
;
  logic clk_sys, rst_n, cfg_wr, en_set, en_clr, connected, user_off, fail_mode;
  logic ion_on, wr_en, active, rejected, running, start_fail, prev;
  logic [1:0] slot_sel, other_slot, pslot;
  logic [7:0] emission, name3;
  logic [3:0] attempts;
  logic [15:0] chamber, sec_p, ion_p, comb;
  wrgh_cfg_s cfg;
  wrgh_policy_e policy;
  int error_cnt = 0;
  int check_count = 0;
  int k, n;
  wrgh_top #(.TICK_CYCLES(10)) i_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_cfg_wr(cfg_wr),
    .i_cfg(cfg), .i_enable_set(en_set), .i_enable_clr(en_clr), .i_partner_slot_select(slot_sel),
    .i_other_ig_slot(other_slot), .i_power_up_policy(policy),
    .i_secondary_pressure(sec_p), .i_ion_pressure(ion_p), .i_ion_connected(connected),
    .i_ion_running(running), .i_ion_start_fail(start_fail), .i_user_ion_off(user_off),
    .i_name_char3(8'h31), .o_ion_on(ion_on), .o_ion_emission(emission),
    .o_combined_pressure(comb), .o_wide_range_enable(wr_en), .o_wide_range_mode_active(active),
    .o_partner_slot(pslot), .o_cfg_rejected(rejected), .o_name_char3(name3), .o_attempts(attempts));
  wrgh_gauge_model i_gauges (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ion_on(ion_on),
    .i_chamber(chamber), .i_fail_mode(fail_mode), .o_secondary_pressure(sec_p),
    .o_ion_pressure(ion_p), .o_ion_running(running), .o_ion_start_fail(start_fail));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic write_cfg(input logic [15:0] on, off, input logic [3:0] lim, input logic [1:0] s);
    @(posedge clk_sys);
    cfg.turn_on_threshold <= on;
    cfg.turn_off_threshold <= off;
    cfg.start_retry_limit <= lim;
    slot_sel <= s;
    cfg_wr <= 1'b1;
    @(posedge clk_sys) cfg_wr <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic enable();
    @(posedge clk_sys) en_set <= 1'b1;
    @(posedge clk_sys) en_set <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wait_ion(input logic v);
    for (k = 0; k < 300 && ion_on !== v; k++) @(negedge clk_sys);
    chk({15'h0000, ion_on}, {15'h0000, v});
  endtask
  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
  initial begin
    {rst_n, cfg_wr, en_set, en_clr, user_off, fail_mode} = 6'h00;
    {connected, slot_sel, other_slot, chamber, cfg} = {1'b1, 2'h0, 2'h2, 16'h0800, 58'h0};
    policy = WRGH_POL_DISABLED_AT_POWER_UP;
    cfg.turn_on_wait = 13'h0003;
    cfg.start_emission_setting = 8'h5a;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(ion_on, 1'b0);
    chk(attempts, 4'h0);
    chk(wr_en, 1'b0);
    chk(comb, 16'h0800);
    $display("reset test done");
    write_cfg(16'h0200, 16'h0100, 4'h3, 2'h1);
    chk({rejected, pslot}, 3'h4);
    write_cfg(16'h0064, 16'h0200, 4'h3, 2'h2);
    chk({rejected, pslot}, 3'h4);
    write_cfg(16'h0064, 16'h0200, 4'h3, 2'h1);
    chk({rejected, pslot}, 3'h1);
    $display("config test done");
    enable();
    @(negedge clk_sys);
    chk({active, name3}, 9'h12a);
    @(posedge clk_sys) chamber <= 16'h0020;
    repeat (15) @(posedge clk_sys);
    chamber <= 16'h0080;
    repeat (20) @(posedge clk_sys);
    chamber <= 16'h0020;
    repeat (25) @(negedge clk_sys);
    chk(ion_on, 1'b0);
    wait_ion(1'b1);
    chk(emission, 8'h5a);
    repeat (10) @(negedge clk_sys);
    chk(comb, 16'h0023);
    chk(attempts, 4'h0);
    @(posedge clk_sys) chamber <= 16'h0300;
    wait_ion(1'b0);
    repeat (6) @(negedge clk_sys);
    chk(comb, 16'h0300);
    $display("handover test done");
    fail_mode <= 1'b1;
    write_cfg(16'h0064, 16'h0200, 4'h2, 2'h1);
    @(posedge clk_sys) chamber <= 16'h0020;
    {n, prev} = {32'h0, 1'b0};
    for (k = 0; k < 400 && wr_en === 1'b1; k++) begin
      @(negedge clk_sys);
      if (ion_on === 1'b1 && !prev) n++;
      prev = ion_on;
    end
    chk(n[15:0], 16'h0002);
    chk(wr_en, 1'b0);
    $display("retry test done");
    fail_mode <= 1'b0;
    enable();
    chk(wr_en, 1'b1);
    @(posedge clk_sys) user_off <= 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(wr_en, 1'b0);
    @(posedge clk_sys) user_off <= 1'b0;
    repeat (4) @(posedge clk_sys);
    enable();
    chk(wr_en, 1'b1);
    @(posedge clk_sys) connected <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk(wr_en, 1'b0);
    $display("cancel test done");
    connected <= 1'b1;
    policy <= WRGH_POL_ENABLED_AT_POWER_UP;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(wr_en, 1'b1);
    policy <= WRGH_POL_SINGLE_PUMP_DOWN;
    write_cfg(16'h0064, 16'h0200, 4'h3, 2'h1);
    enable();
    wait_ion(1'b1);
    repeat (12) @(negedge clk_sys);
    chk(wr_en, 1'b0);
    $display("policy test done");
    stop_test();
  end
endmodule // wrgh_top_test
bind wrgh_top wrgh_asserts u_chk (.i_clk_sys, .i_rst_n, .i_cfg_wr, .i_cfg,
  .i_partner_slot_select, .i_other_ig_slot, .i_secondary_pressure, .i_ion_connected,
  .i_user_ion_off, .o_ion_on, .o_combined_pressure, .o_wide_range_enable,
  .o_wide_range_mode_active, .o_partner_slot, .o_cfg_rejected, .o_name_char3);
`default_nettype wire
